// ==== include/jdp_pkg.sv ====
// jdp_pkg: shared constants, types and layouts for the test and debug port.
// assumes one system clock; test pins are sampled in its domain.
package jdp_pkg;

  // register widths
  localparam int JDP_IR_W = 4; // instruction register width
  localparam int JDP_DR_W = 32; // data register width

  // instruction codes
  localparam logic [3:0] JDP_INS_EXTEST = 4'h0; // drive pins from boundary cells
  localparam logic [3:0] JDP_INS_IDCODE = 4'h1; // identity word
  localparam logic [3:0] JDP_INS_USERCODE = 4'h2; // user code word
  localparam logic [3:0] JDP_INS_SAMPLE = 4'h3; // sample pin levels
  localparam logic [3:0] JDP_INS_DBG_REQ = 4'h8; // chip tap: request debug mode
  localparam logic [3:0] JDP_INS_TILE_RD = 4'h9; // chip tap: read tile word
  localparam logic [3:0] JDP_INS_TILE_WR = 4'hA; // chip tap: write tile word
  localparam logic [3:0] JDP_INS_OTP_RD = 4'hB; // chip tap: read otp word
  localparam logic [3:0] JDP_INS_OTP_WR = 4'hC; // chip tap: write otp word
  localparam logic [3:0] JDP_INS_BYPASS = 4'hF; // one-bit bypass
  localparam logic [3:0] JDP_IR_CAPTURE = 4'h1; // fixed ir capture pattern
  localparam logic [3:0] JDP_IR_RESET = JDP_INS_IDCODE; // ir after test reset

  // security word bit positions
  localparam int JDP_SEC_JTAG_OFF = 0; // blocks tile state and memory access
  localparam int JDP_SEC_OTP_OFF = 13; // blocks otp access from the test port
  localparam int JDP_SEC_DBG_OFF = 14; // blocks the debug sync pin
  localparam int JDP_SEC_UID_LSB = 22; // user identifier low bit
  localparam int JDP_SEC_UID_MSB = 31; // user identifier high bit

  // identity word layout
  localparam int JDP_ID_VER_LSB = 28; // version field [31:28]
  localparam int JDP_ID_PART_LSB = 12; // part number field [27:12]
  localparam int JDP_ID_MFR_LSB = 1; // manufacturer field [11:1]
  localparam logic JDP_ID_ONE = 1'b1; // bit 0 always one

  // user code layout
  localparam int JDP_UC_UID_LSB = 22; // user identifier [31:22]
  localparam int JDP_UC_REV_W = 16; // silicon revision [15:0], [21:16] unused

  // debug sync pin configurations
  localparam logic [1:0] JDP_DBG_OFF = 2'h0; // pin neither driven nor watched
  localparam logic [1:0] JDP_DBG_OUT = 2'h1; // pin pulled low on breakpoint
  localparam logic [1:0] JDP_DBG_IN = 2'h2; // falling edge on pin enters debug

  // tap controller states
  typedef enum logic [3:0] {
    JDP_TLR, JDP_RTI, JDP_SEL_DR, JDP_CAP_DR, JDP_SH_DR, JDP_EX1_DR, JDP_PA_DR,
    JDP_EX2_DR, JDP_UPD_DR, JDP_SEL_IR, JDP_CAP_IR, JDP_SH_IR, JDP_EX1_IR,
    JDP_PA_IR, JDP_EX2_IR, JDP_UPD_IR
  } jdp_tap_state_t;

  // boot sequencer states
  typedef enum logic [1:0] {JDP_BOOT_LOCK, JDP_BOOT_GO, JDP_BOOT_RUN} jdp_boot_state_t;

  // test pins as seen from the device
  typedef struct packed {
    logic tck; // test clock
    logic tms; // mode select
    logic tdi; // serial data in
    logic trst_n; // test reset, active low
  } jdp_pins_t;

  // one tile or otp access issued from the chip tap
  typedef struct packed {
    logic valid; // one-cycle strobe
    logic write; // 1 write, 0 read
    logic otp; // 1 otp, 0 tile memory
    logic [31:0] data; // write data
  } jdp_access_t;

endpackage : jdp_pkg

// ==== src/jdp_tap.sv ====
// jdp_tap: one test access port with 4-bit ir, 32-bit dr and bypass cell.
// assumes tck edges come as one-cycle pulses synchronised to clock_i;
// the owner supplies the word captured into the dr for the current ir.
`timescale 1ns/100ps
`default_nettype none
module jdp_tap
  import jdp_pkg::*;
#(
  parameter int IR_W = JDP_IR_W, // instruction width
  parameter int DR_W = JDP_DR_W // data register width
) (
  input wire logic clock_i, // system clock
  input wire logic rst_n_i, // global reset, async, active low
  input wire logic trst_n_i, // synchronised test reset, active low
  input wire logic tck_rise_i, // test clock rising edge pulse
  input wire logic tck_fall_i, // test clock falling edge pulse
  input wire logic tms_i, // synchronised mode select
  input wire logic tdi_i, // serial data in
  input wire logic [DR_W-1:0] cap_i, // word to capture into dr
  output logic [IR_W-1:0] ir_o, // current instruction
  output logic [DR_W-1:0] dr_o, // dr shift contents
  output logic upd_dr_o, // one-cycle pulse on update-dr
  output logic tdo_o // serial data out, changes on tck fall
);
  import jdp_pkg::*;

  typedef struct packed {
    jdp_tap_state_t st; // controller state
    logic [IR_W-1:0] ir_sh; // ir shift stage
    logic [IR_W-1:0] ir; // active instruction
    logic [DR_W-1:0] dr; // data shift register
    logic byp; // bypass cell
    logic upd; // update pulse
    logic tdo; // output stage
  } jdp_tap_s_t;

  jdp_tap_s_t s_reg;
  jdp_tap_s_t s_next;
  logic bypass; // bypass selected

  // standard sixteen-state walk on tms
  function automatic jdp_tap_state_t step(input jdp_tap_state_t st, input logic m);
    case (st)
      JDP_TLR: step = m ? JDP_TLR : JDP_RTI;
      JDP_RTI: step = m ? JDP_SEL_DR : JDP_RTI;
      JDP_SEL_DR: step = m ? JDP_SEL_IR : JDP_CAP_DR;
      JDP_CAP_DR: step = m ? JDP_EX1_DR : JDP_SH_DR;
      JDP_SH_DR: step = m ? JDP_EX1_DR : JDP_SH_DR;
      JDP_EX1_DR: step = m ? JDP_UPD_DR : JDP_PA_DR;
      JDP_PA_DR: step = m ? JDP_EX2_DR : JDP_PA_DR;
      JDP_EX2_DR: step = m ? JDP_UPD_DR : JDP_SH_DR;
      JDP_UPD_DR: step = m ? JDP_SEL_DR : JDP_RTI;
      JDP_SEL_IR: step = m ? JDP_TLR : JDP_CAP_IR;
      JDP_CAP_IR: step = m ? JDP_EX1_IR : JDP_SH_IR;
      JDP_SH_IR: step = m ? JDP_EX1_IR : JDP_SH_IR;
      JDP_EX1_IR: step = m ? JDP_UPD_IR : JDP_PA_IR;
      JDP_PA_IR: step = m ? JDP_EX2_IR : JDP_PA_IR;
      JDP_EX2_IR: step = m ? JDP_UPD_IR : JDP_SH_IR;
      JDP_UPD_IR: step = m ? JDP_SEL_DR : JDP_RTI;
      default: step = JDP_TLR;
    endcase
  endfunction : step

  assign bypass = (s_reg.ir == IR_W'(JDP_INS_BYPASS));

  // next state: rising edges move and shift, falling edges present tdo
  always_comb begin
    s_next = s_reg;
    s_next.upd = 1'b0;
    if (tck_rise_i) begin
      case (s_reg.st)
        JDP_CAP_DR: begin
          s_next.dr = cap_i; // R2
          s_next.byp = 1'b0;
        end
        JDP_SH_DR: begin
          s_next.dr = {tdi_i, s_reg.dr[DR_W-1:1]}; // R2
          s_next.byp = tdi_i;
        end
        JDP_CAP_IR: s_next.ir_sh = IR_W'(JDP_IR_CAPTURE);
        JDP_SH_IR: s_next.ir_sh = {tdi_i, s_reg.ir_sh[IR_W-1:1]}; // R2
        JDP_UPD_IR: s_next.ir = s_reg.ir_sh;
        JDP_UPD_DR: s_next.upd = 1'b1;
        JDP_TLR: s_next.ir = IR_W'(JDP_IR_RESET);
        default: s_next.ir = s_reg.ir;
      endcase
      s_next.st = step(s_reg.st, tms_i); // R1
    end
    if (tck_fall_i) begin
      if (s_reg.st == JDP_SH_IR) begin
        s_next.tdo = s_reg.ir_sh[0];
      end else if (s_reg.st == JDP_SH_DR) begin
        s_next.tdo = bypass ? s_reg.byp : s_reg.dr[0];
      end
    end
    // test reset low holds the port in reset while low
    if (!trst_n_i) begin
      s_next.st = JDP_TLR; // R5
      s_next.ir = IR_W'(JDP_IR_RESET); // R5
      s_next.upd = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '{st: JDP_TLR, ir: IR_W'(JDP_IR_RESET), default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign ir_o = s_reg.ir;
  assign dr_o = s_reg.dr;
  assign upd_dr_o = s_reg.upd;
  assign tdo_o = s_reg.tdo;

endmodule : jdp_tap
`default_nettype wire

// ==== src/jdp_top.sv ====
// jdp_top: test and debug access logic, two boundary taps and a chip tap in
// one chain, debug sync pin, and boot sequencing after global reset.
// assumes the test pins come from an outside controller on an unrelated clock;
// they are sampled on clock_i, so tck must run well below clock_i / 4.
//
// Notes on behaviour
// R1: two standard boundary taps in the chain
// R2: each tap: 4-bit ir, 32-bit dr
// R3: chip tap reaches tile for code, debug
// R4: controller holds test reset low at power-up
// R5: test reset held low keeps module reset
// R6: output mode: float until breakpoint, then low
// R7: input mode: pin low puts tile in debug
// R8: identity word: version, part, maker, bit0 one
// R9: user code: user id, unused, revision
// R10: user id from security bits 22..31
// R11: global reset asserts asynchronously, resets everything
// R12: after reset wait pll lock, then boot
// R13: reset source holds global reset at power-up
// R14: both resets low until supplies stable
// R15: bus powered: release reset within 10 ms
// R16: release reset 1 ms after io supply good
// R17: jtag-off bit blocks tile state and memory
// R18: otp-off bit refuses otp access from port
// R19: unconfigured debug pin ignored, never driven
`timescale 1ns/100ps
`default_nettype none
module jdp_top
  import jdp_pkg::*;
#(
  parameter logic [3:0] ID_VERSION = 4'h0, // arbitrary value
  parameter logic [15:0] ID_PART = 16'h0001, // arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h001, // arbitrary value
  parameter logic [15:0] SILICON_REV = 16'h0001 // arbitrary value
) (
  input wire logic clock_i, // 40 MHz system clock
  input wire logic rst_n_i, // global reset pin, async, active low
  input wire jdp_pkg::jdp_pins_t pins_i, // raw tck, tms, tdi, test reset
  output logic tdo_o, // chain serial data out
  input wire logic [31:0] sec_word_i, // security word of tile 0
  input wire logic [1:0] dbg_mode_i, // debug pin configuration
  input wire logic tile_break_i, // tile stopped at a breakpoint
  input wire logic dbg_pin_i, // debug pin level
  output logic dbg_pin_o, // debug pin drive value
  output logic dbg_pin_oe_o, // debug pin drive enable, high drives
  output logic debug_enter_o, // one-cycle pulse: tile enters debug
  input wire logic [31:0] tile_rdata_i, // tile word for chip tap reads
  input wire logic [31:0] otp_rdata_i, // otp word for chip tap reads
  output jdp_pkg::jdp_access_t acc_o, // tile or otp access from chip tap
  input wire logic pll_lock_i, // pll lock, async
  input wire logic [1:0] boot_mode_i, // boot mode straps
  output logic [1:0] boot_mode_o, // boot mode caught at boot
  output logic boot_start_o // one-cycle pulse: start booting
);
  import jdp_pkg::*;

  localparam int NTAP = 3; // two boundary taps, then the chip tap

  typedef struct packed {
    jdp_pins_t pin_s1; // first sync stage, read only by stage two
    jdp_pins_t pin_s2; // second sync stage
    logic tck_d; // previous synced tck
    logic lock_s1; // pll lock sync
    logic lock_s2;
    logic dbg_s1; // debug pin sync
    logic dbg_s2;
    logic dbg_d; // previous synced pin level
    jdp_boot_state_t boot; // boot sequencer
    logic boot_start; // boot pulse
    logic [1:0] boot_mode; // caught straps
    logic dbg_oe; // debug pin enable
    logic dbg_enter; // debug entry pulse
    jdp_access_t acc; // access strobe
  } jdp_top_s_t;

  jdp_top_s_t s_reg;
  jdp_top_s_t s_next;

  logic tck_rise; // synced tck rising edge
  logic tck_fall; // synced tck falling edge
  logic [NTAP:0] chain; // serial chain, chain[0] is tdi
  logic [JDP_IR_W-1:0] ir [NTAP]; // per-tap instruction
  logic [JDP_DR_W-1:0] dr [NTAP]; // per-tap shift contents
  logic [JDP_DR_W-1:0] cap [NTAP]; // per-tap capture word
  logic [NTAP-1:0] upd; // per-tap update pulse
  logic [JDP_DR_W-1:0] id_word; // identity word
  logic [JDP_DR_W-1:0] uc_word; // user code word
  logic jtag_off; // tile access blocked
  logic otp_off; // otp access blocked
  logic dbg_off; // debug pin blocked

  assign jtag_off = sec_word_i[JDP_SEC_JTAG_OFF];
  assign otp_off = sec_word_i[JDP_SEC_OTP_OFF];
  assign dbg_off = sec_word_i[JDP_SEC_DBG_OFF];

  // identity word: version, part, maker, then a fixed one
  assign id_word = {ID_VERSION, ID_PART, ID_MAKER, JDP_ID_ONE}; // R8

  // user code: user id from the security word, unused zeros, revision
  assign uc_word = {sec_word_i[JDP_SEC_UID_MSB:JDP_SEC_UID_LSB], // R10
                    (JDP_UC_UID_LSB - JDP_UC_REV_W)'(0), SILICON_REV}; // R9

  assign tck_rise = s_reg.pin_s2.tck & ~s_reg.tck_d;
  assign tck_fall = ~s_reg.pin_s2.tck & s_reg.tck_d;
  assign chain[0] = s_reg.pin_s2.tdi;

  // capture words; boundary cells unmodelled, pin samples read zero
  always_comb begin
    for (int t = 0; t < NTAP; t++) begin
      case (ir[t])
        JDP_INS_IDCODE: cap[t] = id_word; // R8
        JDP_INS_USERCODE: cap[t] = uc_word; // R9
        default: cap[t] = '0;
      endcase
      if (t == NTAP - 1) begin
        // chip tap: refused reads capture zero
        if (ir[t] == JDP_INS_TILE_RD && !jtag_off) begin
          cap[t] = tile_rdata_i; // R3
        end else if (ir[t] == JDP_INS_OTP_RD && !otp_off) begin
          cap[t] = otp_rdata_i; // R18
        end
      end
    end
  end

  // the chain: two boundary taps, then the chip tap
  genvar g;
  generate
    for (g = 0; g < NTAP; g++) begin : g_tap
      jdp_tap #(
        .IR_W(JDP_IR_W),
        .DR_W(JDP_DR_W)
      ) u_tap (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .trst_n_i(s_reg.pin_s2.trst_n),
        .tck_rise_i(tck_rise),
        .tck_fall_i(tck_fall),
        .tms_i(s_reg.pin_s2.tms),
        .tdi_i(chain[g]),
        .cap_i(cap[g]),
        .ir_o(ir[g]),
        .dr_o(dr[g]),
        .upd_dr_o(upd[g]),
        .tdo_o(chain[g+1])
      ); // R1
    end
  endgenerate

  assign tdo_o = chain[NTAP];

  // next state for syncs, debug pin, access strobes and boot
  always_comb begin
    s_next = s_reg;
    s_next.pin_s1 = pins_i;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.tck_d = s_reg.pin_s2.tck;
    s_next.lock_s1 = pll_lock_i;
    s_next.lock_s2 = s_reg.lock_s1;
    s_next.dbg_s1 = dbg_pin_i;
    s_next.dbg_s2 = s_reg.dbg_s1;
    s_next.dbg_d = s_reg.dbg_s2;
    s_next.dbg_enter = 1'b0;
    s_next.boot_start = 1'b0;
    s_next.acc = '0;

    // output mode floats until the tile stops, then pulls low
    s_next.dbg_oe = (dbg_mode_i == JDP_DBG_OUT) && !dbg_off && tile_break_i; // R6 R19

    // input mode: falling level on the pin asks the tile into debug
    if (dbg_mode_i == JDP_DBG_IN && !dbg_off && s_reg.dbg_d && !s_reg.dbg_s2) begin
      s_next.dbg_enter = 1'b1; // R7 R19
    end

    // chip tap update actions, each checked against the security word
    if (upd[NTAP-1]) begin
      case (ir[NTAP-1])
        JDP_INS_DBG_REQ: begin
          if (!jtag_off && dr[NTAP-1][0]) begin
            s_next.dbg_enter = 1'b1; // R3 R17
          end
        end
        JDP_INS_TILE_RD, JDP_INS_TILE_WR: begin
          if (!jtag_off) begin
            s_next.acc.valid = 1'b1; // R3 R17
            s_next.acc.write = (ir[NTAP-1] == JDP_INS_TILE_WR);
            s_next.acc.data = dr[NTAP-1];
          end
        end
        JDP_INS_OTP_RD, JDP_INS_OTP_WR: begin
          if (!otp_off) begin
            s_next.acc.valid = 1'b1; // R18
            s_next.acc.write = (ir[NTAP-1] == JDP_INS_OTP_WR);
            s_next.acc.otp = 1'b1;
            s_next.acc.data = dr[NTAP-1];
          end
        end
        default: s_next.acc = '0;
      endcase
    end

    // boot only once the pll has locked after reset release
    case (s_reg.boot)
      JDP_BOOT_LOCK: begin
        if (s_reg.lock_s2) begin
          s_next.boot = JDP_BOOT_GO; // R12
        end
      end
      JDP_BOOT_GO: begin
        s_next.boot_mode = boot_mode_i; // straps caught after release
        s_next.boot_start = 1'b1; // R12
        s_next.boot = JDP_BOOT_RUN;
      end
      JDP_BOOT_RUN: s_next.boot = JDP_BOOT_RUN;
      default: s_next.boot = JDP_BOOT_LOCK;
    endcase
  end

  // state register; global reset clears all at once
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '{boot: JDP_BOOT_LOCK, default: '0}; // R11
    end else begin
      s_reg <= s_next;
    end
  end

  assign dbg_pin_o = 1'b0; // only ever pulls low
  assign dbg_pin_oe_o = s_reg.dbg_oe;
  assign debug_enter_o = s_reg.dbg_enter;
  assign acc_o = s_reg.acc;
  assign boot_mode_o = s_reg.boot_mode;
  assign boot_start_o = s_reg.boot_start;

endmodule : jdp_top
`default_nettype wire

// ==== tb/jdp_assertions.sv ====
// jdp_assertions: port-level checks for the test and debug port, the debug pin and boot sequencing.
// assumes binding into jdp_top; watched ports sit in the clock_i domain.
`timescale 1ns/100ps
`default_nettype none
module jdp_assertions (
  input wire logic clock_i, // system clock
  input wire logic rst_n_i, // global reset, active low
  input wire jdp_pkg::jdp_pins_t pins_i, // raw test pins
  input wire logic [31:0] sec_word_i, // security word
  input wire logic [1:0] dbg_mode_i, // debug pin mode
  input wire logic tile_break_i, // breakpoint hit
  input wire logic dbg_pin_o, // debug pin value
  input wire logic dbg_pin_oe_o, // debug pin enable
  input wire logic pll_lock_i, // pll lock
  input wire logic [1:0] boot_mode_i, // boot straps
  input wire logic [1:0] boot_mode_o, // straps caught at boot
  input wire logic boot_start_o, // boot pulse
  input wire jdp_pkg::jdp_access_t acc_o // chip tap access
);
  import jdp_pkg::*;
  logic boot_seen_reg; // a boot pulse went by since reset
  logic drv_on; // output mode armed and breakpoint hit
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // remember the first boot, so a repeat stands out
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) boot_seen_reg <= 1'b0;
    else boot_seen_reg <= boot_seen_reg | boot_start_o;
  end
  // a security bit overrides the output mode
  assign drv_on = dbg_mode_i == JDP_DBG_OUT && !sec_word_i[JDP_SEC_DBG_OFF] && tile_break_i;

  a_boot_lock: assert property (boot_start_o |-> $past(pll_lock_i, 2))
    else $error("boot without lock");
  a_boot_once: assert property (boot_start_o |-> !boot_seen_reg)
    else $error("second boot pulse");
  a_boot_mode: assert property (boot_start_o |-> boot_mode_o == boot_mode_i)
    else $error("boot mode not straps");
  a_dbg_low: assert property (dbg_pin_oe_o |-> !dbg_pin_o)
    else $error("debug pin driven high");
  a_dbg_cause: assert property (dbg_pin_oe_o |-> $past(drv_on))
    else $error("pin driven without break");
  a_dbg_drive: assert property (drv_on [*5] |-> dbg_pin_oe_o)
    else $error("pin not pulled at break");
  a_dbg_off: assert property ((dbg_mode_i == JDP_DBG_OFF) [*2] |-> !dbg_pin_oe_o)
    else $error("pin driven while off");
  a_otp_block: assert property (acc_o.valid && acc_o.otp |->
    !$past(sec_word_i[JDP_SEC_OTP_OFF], 2))
    else $error("otp access while blocked");
  a_tile_block: assert property (acc_o.valid && !acc_o.otp |->
    !$past(sec_word_i[JDP_SEC_JTAG_OFF], 2))
    else $error("tile access while blocked");
  a_acc_pulse: assert property (acc_o.valid |=> !acc_o.valid)
    else $error("access strobe too long");
  a_trst_quiet: assert property ((!pins_i.trst_n) [*8] |-> !acc_o.valid)
    else $error("access in test reset");

  c_boot: cover property (boot_start_o);
  c_otp: cover property (acc_o.valid && acc_o.otp);
  c_pin: cover property (dbg_pin_oe_o);
endmodule : jdp_assertions

bind jdp_top jdp_assertions u_chk (
  .clock_i, .rst_n_i, .pins_i, .sec_word_i, .dbg_mode_i, .tile_break_i, .dbg_pin_o,
  .dbg_pin_oe_o, .pll_lock_i, .boot_mode_i, .boot_mode_o, .boot_start_o, .acc_o
);
`default_nettype wire

// ==== tb/jdp_ctrl_model.sv ====
// jdp_ctrl_model: outside controller driving the test pins.
// assumes clock_i paces it; one tck period is 8 clocks (200 ns).
`timescale 1ns/100ps
`default_nettype none
module jdp_ctrl_model (
  input wire logic clock_i, // device clock, paces tck
  input wire logic tdo_i, // chain serial out
  output var jdp_pkg::jdp_pins_t pins_o // tck, tms, tdi, test reset
);
  import jdp_pkg::*;
  // test reset low from power-up, lifted well past 100 ns; tms high, tck low
  initial pins_o = 4'h4;
  // wait n device clocks
  task automatic hold(input int n);
    repeat (n) @(posedge clock_i);
  endtask : hold
  // test reset level; low parks every tap
  task automatic set_trst(input logic lvl);
    pins_o.trst_n <= lvl;
    hold(1);
  endtask : set_trst
  // one tck period; tdo taken late in the high half, once settled
  task automatic step(input logic ms, input logic di, output logic seen);
    pins_o.tck <= 1'b0;
    pins_o.tms <= ms;
    pins_o.tdi <= di;
    hold(4); // shorter halves lose edges
    pins_o.tck <= 1'b1;
    hold(4);
    seen = tdo_i;
  endtask : step
  // tms walk, first bit first; tdi toggles since nobody reads it
  task automatic walk(input logic [5:0] ms, input int n);
    logic d;
    for (int i = 0; i < n; i++) step(ms[i], ~pins_o.tdi, d);
  endtask : walk
  // tck stands low between frames
  task automatic park();
    pins_o.tck <= 1'b0;
    hold(4);
  endtask : park
  // shift n bits lsb first, leaving on the last
  task automatic shift(input logic [95:0] din, input int n, output logic [95:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask : shift
  // load all three instructions; low nibble goes to the chip tap
  task automatic sir(input logic [11:0] ins);
    logic [95:0] q;
    walk(6'h03, 4); // select-dr, select-ir, capture, shift
    shift({84'h0, ins}, 12, q);
    walk(6'h01, 2); // update, idle
    park();
  endtask : sir
  // full scan of the three data registers
  task automatic sdr(input logic [95:0] din, output logic [95:0] dout);
    walk(6'h01, 3); // select, capture, shift
    shift(din, 96, dout);
    walk(6'h01, 2);
    park();
  endtask : sdr
  // five ones reach test-logic-reset from anywhere, then idle
  task automatic treset();
    walk(6'h1F, 6);
    park();
  endtask : treset
endmodule : jdp_ctrl_model
`default_nettype wire

// ==== tb/tb_jtag_debug_port.sv ====
// tb_jtag_debug_port: self-checking bench for the test and debug port.
// assumes the design, checker and controller model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_jtag_debug_port;
  import jdp_pkg::*;
  localparam logic [3:0] T_VER = 4'h6; // arbitrary value
  localparam logic [15:0] T_PART = 16'hB2D4; // arbitrary value
  localparam logic [10:0] T_MAKER = 11'h35A; // arbitrary value
  localparam logic [15:0] T_REV = 16'h0C81; // arbitrary value
  localparam logic [31:0] WDAT = 32'h5A0FC3E1; // access payload, bit 0 set
  localparam logic [3:0] ACC_INS [5] = '{JDP_INS_DBG_REQ, JDP_INS_TILE_RD,
    JDP_INS_TILE_WR, JDP_INS_OTP_RD, JDP_INS_OTP_WR}; // chip tap instructions
  logic clock_i, rst_n_i, tdo_o, tile_break_i, dbg_pin_o, dbg_pin_oe_o, debug_enter_o;
  logic pll_lock_i, boot_start_o, ext_drive, dbg_wire; // ext_drive 1 = released
  logic [31:0] sec_word_i, tile_rdata_i = 32'h0000F00D, otp_rdata_i = 32'h00C0FFEE;
  logic [1:0] dbg_mode_i, boot_mode_i, boot_mode_o;
  jdp_pins_t pins;
  jdp_access_t acc, acc_last;
  int ticks, acc_cnt, dbg_cnt, boot_cnt, err_total, checked;
  // open-drain pin with pull-up: low if either side pulls
  assign dbg_wire = (dbg_pin_oe_o ? dbg_pin_o : 1'b1) & ext_drive;

  jdp_ctrl_model ctrl (.clock_i, .tdo_i(tdo_o), .pins_o(pins));
  jdp_top #(.ID_VERSION(T_VER), .ID_PART(T_PART), .ID_MAKER(T_MAKER),
    .SILICON_REV(T_REV)) dut (
    .clock_i, .rst_n_i, .pins_i(pins), .tdo_o, .sec_word_i, .dbg_mode_i, .tile_break_i,
    .dbg_pin_i(dbg_wire), .dbg_pin_o, .dbg_pin_oe_o, .debug_enter_o, .tile_rdata_i,
    .otp_rdata_i, .acc_o(acc), .pll_lock_i, .boot_mode_i, .boot_mode_o, .boot_start_o);

  // 40 MHz
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // pulse counters and the hang guard
  always @(posedge clock_i) begin
    ticks++;
    if (acc.valid === 1'b1) begin
      acc_cnt++;
      acc_last = acc;
    end
    if (debug_enter_o === 1'b1) dbg_cnt++;
    if (boot_start_o === 1'b1) boot_cnt++;
    if (ticks == 60000) begin
      err_total++;
      results();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : wait_cyc
  task automatic t_boot;
    wait_cyc(20);
    check("boot before lock", boot_cnt, 0);
    pll_lock_i <= 1'b1;
    wait_cyc(30);
    check("boot count", boot_cnt, 1);
    check("boot mode", boot_mode_o, 2'h2);
  endtask : t_boot
  task automatic t_idcode;
    logic [95:0] q;
    ctrl.set_trst(1'b1);
    ctrl.treset();
    ctrl.sdr('0, q);
    check("identity word", q[31:0], {T_VER, T_PART, T_MAKER, 1'b1});
    check("boundary id lsbs", {q[64], q[32]}, 2'b11);
  endtask : t_idcode
  task automatic t_usercode;
    logic [95:0] q;
    logic [9:0] uid;
    for (int k = 0; k < 2; k++) begin
      uid = k ? 10'h2D5 : 10'h000; // unprogrammed, then programmed
      sec_word_i <= {uid, 22'h0};
      ctrl.sir({3{JDP_INS_USERCODE}});
      ctrl.sdr('0, q);
      check("user code", q[31:0], {uid, 6'h00, T_REV});
    end
    sec_word_i <= '0;
  endtask : t_usercode
  // chip in bypass, boundary taps capture zero: 65-bit chain
  task automatic t_chain;
    logic [95:0] q;
    ctrl.sir({JDP_INS_SAMPLE, JDP_INS_EXTEST, JDP_INS_BYPASS});
    ctrl.sdr({3{WDAT}}, q);
    check("boundary 1", q[32:1], 32'h0);
    check("boundary 0", q[64:33], 32'h0);
    check("bypass path", {q[0], q[95:65]}, {1'b0, WDAT[30:0]});
  endtask : t_chain
  // every chip tap code, blocking bit clear then set
  task automatic t_access;
    logic [95:0] q;
    logic [31:0] sec;
    logic [3:0] ins;
    logic blk;
    for (int k = 0; k < 10; k++) begin
      ins = ACC_INS[k / 2];
      blk = k[0];
      sec = '0;
      sec[ins >= JDP_INS_OTP_RD ? JDP_SEC_OTP_OFF : JDP_SEC_JTAG_OFF] = blk;
      sec_word_i <= sec;
      acc_cnt = 0;
      dbg_cnt = 0;
      ctrl.sir({JDP_INS_IDCODE, JDP_INS_IDCODE, ins});
      ctrl.sdr({64'h0, WDAT}, q);
      check("read word", q[31:0], blk ? '0 : ins == JDP_INS_TILE_RD ? tile_rdata_i :
        ins == JDP_INS_OTP_RD ? otp_rdata_i : '0);
      if (ins == JDP_INS_DBG_REQ) check("debug requests", dbg_cnt, !blk);
      else begin
        check("accesses", acc_cnt, !blk);
        if (!blk) check("access data", acc_last.data, WDAT);
        if (!blk) check("access kind", {acc_last.write, acc_last.otp},
          {ins == JDP_INS_TILE_WR || ins == JDP_INS_OTP_WR, ins >= JDP_INS_OTP_RD});
      end
    end
    sec_word_i <= '0;
  endtask : t_access
  // held test reset: no access, ir falls back to identity
  task automatic t_trst;
    logic [95:0] q;
    ctrl.sir({3{JDP_INS_USERCODE}});
    ctrl.set_trst(1'b0);
    acc_cnt = 0;
    ctrl.sir({JDP_INS_IDCODE, JDP_INS_IDCODE, JDP_INS_TILE_WR});
    ctrl.sdr({64'h0, WDAT}, q);
    check("access in test reset", acc_cnt, 0);
    ctrl.set_trst(1'b1);
    ctrl.hold(4);
    ctrl.walk(6'h00, 1); // to idle
    ctrl.sdr('0, q);
    check("ir after test reset", q[31:0], {T_VER, T_PART, T_MAKER, 1'b1});
  endtask : t_trst
  task automatic t_dbg_pin;
    dbg_cnt = 0;
    tile_break_i <= 1'b1;
    ext_drive <= 1'b0;
    wait_cyc(8);
    check("off drive", dbg_pin_oe_o, 0);
    check("off watch", dbg_cnt, 0);
    ext_drive <= 1'b1;
    tile_break_i <= 1'b0;
    dbg_mode_i <= JDP_DBG_OUT;
    wait_cyc(6);
    check("float before break", dbg_pin_oe_o, 0);
    tile_break_i <= 1'b1;
    wait_cyc(4);
    check("pulled at break", {dbg_pin_oe_o, dbg_wire}, 2'b10);
    rst_n_i <= 1'b0;
    #1;
    check("async reset", dbg_pin_oe_o, 0);
    wait_cyc(3);
    rst_n_i <= 1'b1;
    boot_cnt = 0;
    wait_cyc(30);
    check("reboot", boot_cnt, 1);
    tile_break_i <= 1'b0;
    dbg_mode_i <= JDP_DBG_IN;
    dbg_cnt = 0;
    wait_cyc(4);
    ext_drive <= 1'b0;
    wait_cyc(8);
    check("enter from pin", dbg_cnt, 1);
  endtask : t_dbg_pin
  task automatic results;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // global reset held 10 clocks (250 ns), past the 100 ns floor
  initial begin
    rst_n_i = 1'b0;
    sec_word_i = '0;
    dbg_mode_i = JDP_DBG_OFF;
    tile_break_i = 1'b0;
    ext_drive = 1'b1;
    pll_lock_i = 1'b0;
    boot_mode_i = 2'h2;
    {ticks, acc_cnt, dbg_cnt, boot_cnt, err_total, checked} = '0;
    wait_cyc(9);
    check("outputs in reset", {dbg_pin_oe_o, boot_start_o, acc.valid, debug_enter_o}, 0);
    wait_cyc(1);
    rst_n_i <= 1'b1;
    t_boot();
    t_idcode();
    t_usercode();
    t_chain();
    t_access();
    t_trst();
    t_dbg_pin();
    results();
  end
endmodule : tb_jtag_debug_port
`default_nettype wire
